// ---- refmon_defs.svh ----
// Offsets, field positions, reset values and rate codes of the reference monitor register slice.
// Assumes an 8-bit register port addressed by byte offset.
`ifndef REFMON_DEFS_SVH
`define REFMON_DEFS_SVH
`define MON_MASK_LOW_ADDR 8'h0c
`define MON_MASK_HIGH_ADDR 8'h0d
`define RATE_LOW_ADDR 8'h10
`define RATE_HIGH_ADDR 8'h11
`define MON_MASK_RESET 8'hff
`define MON_GATE_RESET 4'hf
`define REF_MASK_RESET 3'h0
`define RATE_UNKNOWN 4'hf
`define RATE_LAST_VALID 4'ha
`define MON_SINGLE_BIT 0
`define MON_COARSE_BIT 1
`define MON_SOAK_BIT 2
`define MON_PRECISE_BIT 3
`endif

// ---- refmon_pkg.sv ----
// Types shared by the reference monitor register slice.
// Assumes refmon_defs.svh is compiled alongside.
package refmon_pkg;
  typedef struct packed {
    logic precise;
    logic soak;
    logic coarse;
    logic single;
  } mon_fail_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

// ---- rate_code_hold.sv ----
// One reference's detected-rate field holder.
// Assumes the detector presents a code with a one-cycle valid strobe.
`timescale 1ns/1ns
`include "refmon_defs.svh"
module rate_code_hold (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rate_valid,
  input wire logic [3:0] rate_in,
  input wire logic rate_lost,
  output logic [3:0] rate_code_q
);
  // Unassigned codes are dropped so the field never shows them
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rate_code_q <= `RATE_UNKNOWN;
    end else if (rate_lost) begin
      rate_code_q <= `RATE_UNKNOWN;
    end else if (rate_valid && rate_in <= `RATE_LAST_VALID) begin
      rate_code_q <= rate_in;
    end
  end

  a_no_unassigned: assert property (@(posedge sys_clk) disable iff (rst)
    (rate_code_q <= `RATE_LAST_VALID) || (rate_code_q == `RATE_UNKNOWN))
    else $error("unassigned rate code reported");
  a_lost_unknown: assert property (@(posedge sys_clk) disable iff (rst)
    rate_lost |=> rate_code_q == `RATE_UNKNOWN)
    else $error("rate field not unknown after loss");
endmodule

// ---- ref_monitor_mask_and_freq_detect.sv ----
// Reference monitor interrupt masks and detected-rate status registers.
// Assumes a synchronous 8-bit register port and monitors that pulse fail events.
// The reset-to-zero reference mask and the rate detectors sit outside and arrive as ports.
// Function
// - Second input mask at 0x0c bits 7:4
// - Third input mask at 0x0d bits 3:0
// - Mask bit 0 gates single-cycle failure
// - Mask bit 1 gates coarse-frequency failure
// - Mask bit 2 gates guard-soak failure
// - Mask bit 3 gates precise-frequency failure
// - Masks reset to all ones, read/write
// - 0x10 bits 3:0 first input rate
// - 0x10 bits 7:4 second input rate
// - 0x11 bits 3:0 third rate, rest reserved
// - Undetected rate reads all ones
// - Four sticky fail flags per input
// - Per-input reference mask resets to zero
`timescale 1ns/1ns
`include "refmon_defs.svh"
module ref_monitor_mask_and_freq_detect (
  input wire logic sys_clk,
  input wire logic rst,
  input wire refmon_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata_q,
  input wire refmon_pkg::mon_fail_t [2:0] mon_fail_evt,
  input wire logic [2:0] fail_clear,
  input wire logic [2:0] ref_fail_mask,
  input wire logic [2:0] rate_valid,
  input wire logic [11:0] rate_in,
  input wire logic [2:0] rate_lost,
  output logic [3:0] first_input_monitor_gate_q,
  output refmon_pkg::mon_fail_t [2:0] fail_flags_q,
  output logic ref_fail_irq_q
);
  logic [3:0] second_input_monitor_gate_q;
  logic [3:0] third_input_monitor_gate_q;
  logic [3:0] rate_code [2:0];
  logic [3:0] gate [2:0];
  logic [2:0] ref_pending;
  logic irq_d;

  // Write strobe decode shared by both mask registers
  function automatic logic wr_hit(input refmon_pkg::reg_req_t req, input logic [7:0] addr);
    return req.wr && (req.addr == addr);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Mask registers; first input's field lives outside this slice but the
  // low nibble of 0x0c is kept here so the byte reads back whole.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      first_input_monitor_gate_q <= `MON_GATE_RESET;
      second_input_monitor_gate_q <= `MON_GATE_RESET;
    end else if (wr_hit(reg_req, `MON_MASK_LOW_ADDR)) begin
      first_input_monitor_gate_q <= reg_req.wdata[3:0];
      second_input_monitor_gate_q <= reg_req.wdata[7:4];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      third_input_monitor_gate_q <= `MON_GATE_RESET;
    end else if (wr_hit(reg_req, `MON_MASK_HIGH_ADDR)) begin
      third_input_monitor_gate_q <= reg_req.wdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky fail flags; a new event beats a clear in the same cycle
  // so a failure landing on the clear cycle is never lost.
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_ref
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          fail_flags_q[g] <= '0;
        end else if (fail_clear[g]) begin
          fail_flags_q[g] <= mon_fail_evt[g];
        end else begin
          fail_flags_q[g] <= fail_flags_q[g] | mon_fail_evt[g];
        end
      end

      rate_code_hold u_rate (
        .sys_clk(sys_clk),
        .rst(rst),
        .rate_valid(rate_valid[g]),
        .rate_in(rate_in[g*4 +: 4]),
        .rate_lost(rate_lost[g]),
        .rate_code_q(rate_code[g])
      );

      assign ref_pending[g] = ref_fail_mask[g] && (fail_flags_q[g] & gate[g]) != 4'h0;

      a_flags_keep: assert property (@(posedge sys_clk) disable iff (rst)
        !fail_clear[g] |=> (fail_flags_q[g] & $past(fail_flags_q[g])) == $past(fail_flags_q[g]))
        else $error("sticky fail flag dropped without clear");
    end
  endgenerate

  // First input's gate is a local copy; the other two are this slice's fields
  assign gate[0] = first_input_monitor_gate_q;
  assign gate[1] = second_input_monitor_gate_q;
  assign gate[2] = third_input_monitor_gate_q;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt: bit k of a gate enables flag field k (single, coarse, soak, precise)
  // One cycle of lag is traded for a pin driven straight from a flop
  assign irq_d = |ref_pending;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ref_fail_irq_q <= 1'b0;
    end else begin
      ref_fail_irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, registered; writes to the rate registers fall through with no effect
  // Unmapped offsets and the reserved nibbles read as zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        `MON_MASK_LOW_ADDR: reg_rdata_q <= {second_input_monitor_gate_q, first_input_monitor_gate_q};
        `MON_MASK_HIGH_ADDR: reg_rdata_q <= {4'h0, third_input_monitor_gate_q};
        `RATE_LOW_ADDR: reg_rdata_q <= {rate_code[1], rate_code[0]};
        `RATE_HIGH_ADDR: reg_rdata_q <= {4'h0, rate_code[2]};
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Gating checks: each pins a single flag so no other source can raise
  // or hide the interrupt while it is looked at.
  a_single_gate: assert property (@(posedge sys_clk) disable iff (rst)
    (fail_flags_q == 12'h001 && ref_fail_mask[0] && first_input_monitor_gate_q[`MON_SINGLE_BIT])
    |=> ref_fail_irq_q)
    else $error("single-cycle failure did not interrupt");
  a_single_block: assert property (@(posedge sys_clk) disable iff (rst)
    (fail_flags_q == 12'h100 && !third_input_monitor_gate_q[`MON_SINGLE_BIT]) |=> !ref_fail_irq_q)
    else $error("masked single-cycle failure interrupted");
  a_coarse_gate: assert property (@(posedge sys_clk) disable iff (rst)
    (fail_flags_q == 12'h020 && ref_fail_mask[1] && second_input_monitor_gate_q[`MON_COARSE_BIT])
    |=> ref_fail_irq_q)
    else $error("coarse failure did not interrupt");
  a_coarse_block: assert property (@(posedge sys_clk) disable iff (rst)
    (fail_flags_q == 12'h020 && !second_input_monitor_gate_q[`MON_COARSE_BIT]) |=> !ref_fail_irq_q)
    else $error("masked coarse failure interrupted");
  a_soak_gate: assert property (@(posedge sys_clk) disable iff (rst)
    (fail_flags_q == 12'h400 && ref_fail_mask[2] && third_input_monitor_gate_q[`MON_SOAK_BIT])
    |=> ref_fail_irq_q)
    else $error("soak failure did not interrupt");
  a_soak_block: assert property (@(posedge sys_clk) disable iff (rst)
    (fail_flags_q == 12'h400 && !third_input_monitor_gate_q[`MON_SOAK_BIT]) |=> !ref_fail_irq_q)
    else $error("masked soak failure interrupted");
  a_precise_gate: assert property (@(posedge sys_clk) disable iff (rst)
    (fail_flags_q == 12'h800 && ref_fail_mask[2] && third_input_monitor_gate_q[`MON_PRECISE_BIT])
    |=> ref_fail_irq_q)
    else $error("precise failure did not interrupt");
  a_precise_block: assert property (@(posedge sys_clk) disable iff (rst)
    (fail_flags_q == 12'h080 && !second_input_monitor_gate_q[`MON_PRECISE_BIT]) |=> !ref_fail_irq_q)
    else $error("masked precise failure interrupted");

  ////////////////////////////////////////////////////////////////////////
  // Reference mask and sticky flag checks
  a_ref_mask_block: assert property (@(posedge sys_clk) disable iff (rst)
    (ref_fail_mask == 3'h0) |=> !ref_fail_irq_q)
    else $error("reference mask did not block");
  a_irq_needs_flag: assert property (@(posedge sys_clk) disable iff (rst)
    (fail_flags_q == 12'h000) |=> !ref_fail_irq_q)
    else $error("interrupt without any fail flag");
  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    (fail_flags_q[1].precise && !fail_clear[1]) |=> fail_flags_q[1].precise)
    else $error("fail flag lost without clear");
  a_event_wins: assert property (@(posedge sys_clk) disable iff (rst)
    (mon_fail_evt[1].single && fail_clear[1]) |=> fail_flags_q[1].single)
    else $error("event lost to a clear in the same cycle");
  a_clear_drops: assert property (@(posedge sys_clk) disable iff (rst)
    (fail_clear[0] && mon_fail_evt[0] == 4'h0) |=> fail_flags_q[0] == 4'h0)
    else $error("fail flags not cleared");

  ////////////////////////////////////////////////////////////////////////
  // Register port checks; a read in the cycle of a write sees the old value,
  // so the readback checks leave that case out.
  a_mask_low_write: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_req.wr && reg_req.addr == `MON_MASK_LOW_ADDR)
    |=> {second_input_monitor_gate_q, first_input_monitor_gate_q} == $past(reg_req.wdata))
    else $error("low mask write not stored");
  a_mask_write: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_req.wr && reg_req.addr == `MON_MASK_HIGH_ADDR)
    |=> third_input_monitor_gate_q == $past(reg_req.wdata[3:0]))
    else $error("third mask write not stored");
  a_ro_write_ignored: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_req.wr && (reg_req.addr == `RATE_LOW_ADDR || reg_req.addr == `RATE_HIGH_ADDR))
    |=> $stable(second_input_monitor_gate_q) && $stable(third_input_monitor_gate_q))
    else $error("write to a rate register changed a mask");
  a_mask_readback: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_req.rd && reg_req.addr == `MON_MASK_LOW_ADDR && !reg_req.wr)
    |=> reg_rdata_q[7:4] == second_input_monitor_gate_q)
    else $error("second mask readback wrong");
  a_mask_high_read: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_req.rd && reg_req.addr == `MON_MASK_HIGH_ADDR) |=> reg_rdata_q[7:4] == 4'h0)
    else $error("reserved mask bits not zero");
  a_rate_read: assert property (@(posedge sys_clk) disable iff (rst)
    reg_req.rd && reg_req.addr == `RATE_HIGH_ADDR |=> reg_rdata_q[7:4] == 4'h0)
    else $error("reserved rate bits not zero");
  a_rate_pairing: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_req.rd && reg_req.addr == `RATE_LOW_ADDR)
    |=> reg_rdata_q == {$past(rate_code[1]), $past(rate_code[0])})
    else $error("rate fields paired wrongly");
  a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_req.rd && reg_req.addr != `MON_MASK_LOW_ADDR && reg_req.addr != `MON_MASK_HIGH_ADDR
      && reg_req.addr != `RATE_LOW_ADDR && reg_req.addr != `RATE_HIGH_ADDR) |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (@(posedge sys_clk) disable iff (rst)
    !reg_req.rd |=> $stable(reg_rdata_q))
    else $error("read data changed without a read");
endmodule

// ---- testbench.sv ----
// Self-checking bench for the reference monitor mask and detected-rate register slice.
// Assumes refmon_pkg, refmon_defs.svh and the design modules are compiled first.
`timescale 1ns/1ns
`include "refmon_defs.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
////////////////////////////////////////////////////////////////////////////////
module testbench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  refmon_pkg::reg_req_t req = '0;
  refmon_pkg::mon_fail_t [2:0] evt = '0;
  logic [2:0] clr = '0, rfm = '0, rv = '0, lost = '0;
  logic [11:0] rin = '0;
  logic [7:0] rdata;
  logic [3:0] gate0;
  refmon_pkg::mon_fail_t [2:0] flags;
  logic irq;
  logic [3:0] gate [3];
  logic [3:0] rate [3];
  integer seed = 18001, num_errors = 0, checks_done = 0;
  int r, b, c, p;

  ref_monitor_mask_and_freq_detect u_dut (.sys_clk(sys_clk), .rst(rst), .reg_req(req), .reg_rdata_q(rdata),
    .mon_fail_evt(evt), .fail_clear(clr), .ref_fail_mask(rfm), .rate_valid(rv), .rate_in(rin),
    .rate_lost(lost), .first_input_monitor_gate_q(gate0), .fail_flags_q(flags), .ref_fail_irq_q(irq));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
////////////////////////////////////////////////////////////////////////////////
  // Codes above the last assigned rate are dropped, the old field stays
  function automatic logic [3:0] rate_next(input logic [3:0] old, input logic [3:0] code);
    return (code <= `RATE_LAST_VALID) ? code : old;
  endfunction
  function automatic logic irq_exp(input int ri, input int bi);
    return gate[ri][bi] & rfm[ri];
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Request is dropped for one idle cycle so no signal is driven twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    cyc(1);
    req = '0;
    cyc(1);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    cyc(1);
    req = '0;
    `CHK(rdata, e)
    cyc(1);
  endtask
  task automatic end_of_test();
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    cyc(1);
    rd_chk(`MON_MASK_LOW_ADDR, `MON_MASK_RESET);
    rd_chk(`MON_MASK_HIGH_ADDR, 8'h0f);
    rd_chk(`RATE_LOW_ADDR, 8'hff);
    rd_chk(`RATE_HIGH_ADDR, 8'h0f);
    rd_chk(8'h0e, 8'h00);
    $display("test reset_values done");
    // Pass 0 all open, pass 1 reference masks shut, pass 2 monitor masks shut, then random
    for (p = 0; p < 6; p++) begin
      for (r = 0; r < 3; r++) gate[r] = (p == 0) ? 4'hf : (p == 2) ? 4'h0 : 4'($random(seed));
      rfm = (p == 1) ? 3'h0 : (p < 3) ? 3'h7 : 3'($random(seed));
      wr(`MON_MASK_LOW_ADDR, {gate[1], gate[0]});
      wr(`MON_MASK_HIGH_ADDR, {4'h0, gate[2]});
      rd_chk(`MON_MASK_LOW_ADDR, {gate[1], gate[0]});
      rd_chk(`MON_MASK_HIGH_ADDR, {4'h0, gate[2]});
      `CHK(gate0, gate[0])
      for (r = 0; r < 3; r++) begin
        for (b = 0; b < 4; b++) begin
          evt[r][b] = 1'b1;
          cyc(1);
          evt = '0;
          `CHK(flags[r], 4'(1 << b))
          cyc(1);
          `CHK(irq, irq_exp(r, b))
          clr[r] = 1'b1;
          cyc(1);
          clr = '0;
          cyc(1);
          `CHK({flags[r], irq}, 5'h00)
        end
      end
    end
    $display("test monitor_gating done");
    // An event landing on its clear cycle must survive the clear
    evt[1][0] = 1'b1;
    clr[1] = 1'b1;
    cyc(1);
    evt = '0;
    clr = '0;
    `CHK(flags[1], 4'h1)
    cyc(1);
    clr[1] = 1'b1;
    cyc(1);
    clr = '0;
    `CHK(flags[1], 4'h0)
    // A read in the cycle of a write returns the old value
    req = '{wr: 1'b1, rd: 1'b1, addr: `MON_MASK_HIGH_ADDR, wdata: {4'h0, ~gate[2]}};
    cyc(1);
    req = '0;
    `CHK(rdata, {4'h0, gate[2]})
    gate[2] = ~gate[2];
    cyc(1);
    rd_chk(`MON_MASK_HIGH_ADDR, {4'h0, gate[2]});
    wr(8'h0e, {~gate[1], ~gate[0]});
    rd_chk(`MON_MASK_LOW_ADDR, {gate[1], gate[0]});
    $display("test corner_cases done");
    for (r = 0; r < 3; r++) rate[r] = `RATE_UNKNOWN;
    wr(`RATE_LOW_ADDR, 8'h00);
    wr(`RATE_HIGH_ADDR, 8'h00);
    rd_chk(`RATE_LOW_ADDR, 8'hff);
    rd_chk(`RATE_HIGH_ADDR, 8'h0f);
    for (c = 0; c < 48; c++) begin
      r = c % 3;
      rin = 12'($random(seed));
      rin[r*4+:4] = 4'(c / 3);
      rv[r] = 1'b1;
      cyc(1);
      rv = '0;
      rate[r] = rate_next(rate[r], 4'(c / 3));
      rd_chk(`RATE_LOW_ADDR, {rate[1], rate[0]});
      rd_chk(`RATE_HIGH_ADDR, {4'h0, rate[2]});
    end
    lost = 3'h7;
    cyc(1);
    lost = '0;
    rd_chk(`RATE_LOW_ADDR, 8'hff);
    rd_chk(`RATE_HIGH_ADDR, 8'h0f);
    $display("test rate_codes done");
    // Reset in mid-run returns every field to its reset value
    wr(`MON_MASK_LOW_ADDR, 8'h00);
    wr(`MON_MASK_HIGH_ADDR, 8'h00);
    rin = '0;
    rv = 3'h7;
    cyc(1);
    rv = '0;
    rd_chk(`RATE_LOW_ADDR, 8'h00);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(1);
    rd_chk(`MON_MASK_LOW_ADDR, `MON_MASK_RESET);
    rd_chk(`MON_MASK_HIGH_ADDR, 8'h0f);
    rd_chk(`RATE_LOW_ADDR, 8'hff);
    rd_chk(`RATE_HIGH_ADDR, 8'h0f);
    `CHK(gate0, 4'hf)
    $display("test mid_reset done");
    end_of_test();
  end
endmodule
